// File: design/hpic_pkg.sv
// Package with constants and carrier types for the host port interrupt and buffer control.
package hpic_pkg;

  localparam logic [2:0] HPIC_SYNC_RST  = 3'h7;
  localparam logic       HPIC_PIN_IDLE  = 1'h1;
  localparam logic       HPIC_XCVR_IDLE = 1'h1;
  localparam logic       HPIC_ACK_IDLE  = 1'h1;
  localparam int         HPIC_STEER_A   = 0;

  typedef enum logic [1:0] {
    HPIC_IDLE = 2'h0,
    HPIC_BUSY = 2'h1,
    HPIC_DONE = 2'h3
  } hpic_state_t;

  typedef struct packed {
    logic status_irq_bit;
    logic data_avail_irq_bit;
    logic host_irq_global_en;
    logic irq_pin_steer;
    logic irq_b_dir_ctl_wr;
    logic irq_b_dir_ctl_val;
    logic fifo_dma_en_n;
    logic merged_dma_req_en;
    logic fifo_mode;
  } hpic_ctl_t;

  typedef struct packed {
    logic       fifo_flag;
    logic       fifo_flag_en;
    logic       dma_rdy_in;
    logic       dma_rdy_out;
  } hpic_fifo_t;

endpackage : hpic_pkg

// File: design/hpic_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
`timescale 1ns/100ps
module hpic_sync
  import hpic_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Pin and result
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rs;
  } hpic_sync_st_t;

  hpic_sync_st_t s_q;
  hpic_sync_st_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.sh = {s_q.sh[1:0], pin};
    s_d.rs = 1'b0;
    // Only the second and third stages are compared; the first feeds the second alone.
    if (s_q.sh[1] == s_q.sh[2] && s_q.sh[2] != s_q.lvl) begin
      s_d.lvl = s_q.sh[2];
      s_d.rs  = s_q.sh[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Reset to the idle high level of the pins, so that release of reset shows no false edge.
      s_q <= '{sh: HPIC_SYNC_RST, lvl: HPIC_PIN_IDLE, rs: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
  assign rise  = s_q.rs;

endmodule : hpic_sync

// File: design/hpic_top.sv
// Host port side-band logic: host interrupts, pin B modes, transceiver and acknowledge.
`timescale 1ns/100ps
// Operation
// - Writing status or data-available interrupt bit sets a pending host interrupt.
// - An enabled active FIFO status flag also sets a pending interrupt.
// - Global enable gates both host interrupt pins.
// - Pin A low when pending, enabled and steer is 0.
// - Pin B low when pending, enabled and steer is 1.
// - Direction bit 0 makes pin B an input.
// - Rising edge on input pin B sets inbound flag and internal interrupt.
// - Direction bit loads the strap value on the first clock after reset release; reset itself clears it to 0.
// - FIFO mode with FIFO DMA enabled and merge bit drives ORed DMA ready high on pin B.
// - Merge bit returns address lines 14 and 13 to shared RAM addressing.
// - Transceiver direction high for device-to-host, low for host-to-device.
// - Transceiver enable low while a transfer is in progress.
// - Acknowledge after access; host releases select and keeps address valid (hpic_host inverts the address each clock while acknowledge is low).
// - FIFO DMA enabled when active-low DMA enable bit is 0.
// - Top address bit low selects shared RAM, high selects port registers.
// - Read/write line high reads on normal cycles; reversed on DMA cycles.
module hpic_top
  import hpic_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Strap sampled after reset
  input  wire logic        irq_b_dir_strap,
  // Internal processor control
  input  wire hpic_ctl_t   ctl,
  input  wire logic        irq_clear,
  input  wire logic        inbound_clear,
  input  wire hpic_fifo_t  fifo,
  // Host bus pins
  input  wire logic        host_cs_n,
  input  wire logic        host_rw_n,
  input  wire logic        host_dma_cyc,
  input  wire logic [16:0] host_addr,
  input  wire logic        access_done,
  // Pin B three signals
  input  wire logic        host_irq_b_in,
  output logic             host_irq_b_out,
  output logic             host_irq_b_oe,
  // Other outputs
  output logic             host_irq_a_n,
  output logic             inbound_irq_flag,
  output logic             cpu_irq,
  output logic             irq_b_dir_ctl,
  output logic             addr_14_13_ram,
  output logic             ram_sel,
  output logic             reg_sel,
  output logic             host_is_read,
  output logic             xcvr_dir,
  output logic             xcvr_en_n,
  output logic             host_ack_n
);

  typedef struct packed {
    logic        strap_done;
    logic        dir;
    logic        pend;
    logic        a_n;
    logic        b_out;
    logic        b_oe;
    logic        inb;
    logic        cirq;
    logic        a1413;
    logic        ram;
    logic        regs;
    logic        rd;
    logic        xdir;
    logic        xen_n;
    logic        ack_n;
    hpic_state_t st;
  } hpic_top_st_t;

  hpic_top_st_t s_q;
  hpic_top_st_t s_d;
  logic         b_lvl;
  logic         b_rise;
  logic         cs_lvl;
  logic         fifo_dma;
  logic         merged;
  logic         fire;

  hpic_sync u_sync_b (
    .mclk  (mclk),
    .nrst  (nrst),
    .pin   (host_irq_b_in),
    .level (b_lvl),
    .rise  (b_rise)
  );

  hpic_sync u_sync_cs (
    .mclk  (mclk),
    .nrst  (nrst),
    .pin   (host_cs_n),
    .level (cs_lvl),
    .rise  ()
  );

  always_comb begin
    fifo_dma = ~ctl.fifo_dma_en_n;
    merged   = ctl.fifo_mode & fifo_dma & ctl.merged_dma_req_en;
    fire     = s_q.pend & ctl.host_irq_global_en;
    s_d      = s_q;
    s_d.cirq = 1'b0;
    // The strap is caught by a clocked step after reset release, never by the reset itself.
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.dir        = irq_b_dir_strap;
    end else if (ctl.irq_b_dir_ctl_wr) begin
      s_d.dir = ctl.irq_b_dir_ctl_val;
    end
    // Set wins over clear so a late event is not lost.
    if (irq_clear) begin
      s_d.pend = 1'b0;
    end
    if (ctl.status_irq_bit || ctl.data_avail_irq_bit) begin
      s_d.pend = 1'b1;
    end
    if (fifo.fifo_flag && fifo.fifo_flag_en) begin
      s_d.pend = 1'b1;
    end
    s_d.a_n = ~(fire && (int'(ctl.irq_pin_steer) == HPIC_STEER_A));
    if (merged) begin
      s_d.b_oe  = 1'b1;
      s_d.b_out = fifo.dma_rdy_in | fifo.dma_rdy_out;
    end else if (!s_q.dir) begin
      s_d.b_oe  = 1'b0;
      s_d.b_out = HPIC_PIN_IDLE;
    end else begin
      s_d.b_oe  = 1'b1;
      s_d.b_out = ~(fire && ctl.irq_pin_steer);
    end
    if (inbound_clear) begin
      s_d.inb = 1'b0;
    end
    if (!s_q.dir && !merged && b_rise) begin
      s_d.inb  = 1'b1;
      s_d.cirq = 1'b1;
    end
    s_d.a1413 = ctl.merged_dma_req_en;
    s_d.ram   = ~host_addr[16];
    s_d.regs  = host_addr[16];
    s_d.rd    = host_dma_cyc ? ~host_rw_n : host_rw_n;
    s_d.xdir  = s_d.rd;
    case (s_q.st)
      HPIC_IDLE: begin
        if (!cs_lvl) begin
          s_d.st    = HPIC_BUSY;
          s_d.xen_n = 1'b0;
        end
      end
      HPIC_BUSY: begin
        if (access_done) begin
          s_d.st    = HPIC_DONE;
          s_d.xen_n = HPIC_XCVR_IDLE;
          s_d.ack_n = 1'b0;
        end
      end
      HPIC_DONE: begin
        if (cs_lvl) begin
          s_d.st    = HPIC_IDLE;
          s_d.ack_n = HPIC_ACK_IDLE;
        end
      end
      default: begin
        s_d.st = HPIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '{strap_done: 1'b0, dir: 1'b0, pend: 1'b0, a_n: HPIC_PIN_IDLE,
               b_out: HPIC_PIN_IDLE, b_oe: 1'b0, inb: 1'b0, cirq: 1'b0, a1413: 1'b0,
               ram: 1'b0, regs: 1'b0, rd: 1'b0, xdir: 1'b0, xen_n: HPIC_XCVR_IDLE,
               ack_n: HPIC_ACK_IDLE, st: HPIC_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign host_irq_a_n     = s_q.a_n;
  assign host_irq_b_out   = s_q.b_out;
  assign host_irq_b_oe    = s_q.b_oe;
  assign inbound_irq_flag = s_q.inb;
  assign cpu_irq          = s_q.cirq;
  assign irq_b_dir_ctl    = s_q.dir;
  assign addr_14_13_ram   = s_q.a1413;
  assign ram_sel          = s_q.ram;
  assign reg_sel          = s_q.regs;
  assign host_is_read     = s_q.rd;
  assign xcvr_dir         = s_q.xdir;
  assign xcvr_en_n        = s_q.xen_n;
  assign host_ack_n       = s_q.ack_n;

  AST_GATE_A: assert property (@(posedge mclk) disable iff (!nrst)
    !host_irq_a_n |-> $past(ctl.host_irq_global_en)) else $error("Pin A without enable.");
  AST_PIN_A: assert property (@(posedge mclk) disable iff (!nrst)
    !host_irq_a_n |-> $past(s_q.pend) && !$past(ctl.irq_pin_steer))
    else $error("Pin A low without steer 0.");
  AST_PIN_B: assert property (@(posedge mclk) disable iff (!nrst)
    host_irq_b_oe && !host_irq_b_out && !$past(merged) |-> $past(ctl.irq_pin_steer))
    else $error("Pin B low without steer 1.");
  AST_DIR_IN: assert property (@(posedge mclk) disable iff (!nrst)
    s_q.strap_done && !irq_b_dir_ctl && !merged |=> !host_irq_b_oe)
    else $error("Pin B driven as input.");
  AST_INB: assert property (@(posedge mclk) disable iff (!nrst)
    b_rise && !s_q.dir && !merged |=> inbound_irq_flag && cpu_irq)
    else $error("Rising edge lost.");
  AST_SET: assert property (@(posedge mclk) disable iff (!nrst)
    ctl.status_irq_bit |=> s_q.pend) else $error("Pending not set.");
  AST_MERGE: assert property (@(posedge mclk) disable iff (!nrst)
    merged && fifo.dma_rdy_out |=> host_irq_b_oe && host_irq_b_out)
    else $error("Merged request missing.");
  AST_ACK: assert property (@(posedge mclk) disable iff (!nrst)
    s_q.st == HPIC_BUSY && access_done |=> !host_ack_n && xcvr_en_n)
    else $error("Acknowledge missing.");
  AST_RW: assert property (@(posedge mclk) disable iff (!nrst)
    host_dma_cyc && host_rw_n |=> !host_is_read) else $error("DMA direction wrong.");

endmodule : hpic_top

// File: testbench/hpic_host.sv
// Host processor model that drives the host port pins.
`timescale 1ns/100ps
module hpic_host
  import hpic_pkg::*;
(
  // Clock and commands from the bench
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [18:0] cmd,
  input  wire logic        irq_drv,
  // Device pins
  input  wire logic        host_ack_n,
  input  wire logic        host_irq_b_out,
  input  wire logic        host_irq_b_oe,
  output logic             host_cs_n,
  output logic             host_rw_n,
  output logic             host_dma_cyc,
  output logic [16:0]      host_addr,
  output logic             irq_pin
);
  initial host_cs_n = 1'h1;
  initial {host_rw_n, host_dma_cyc, host_addr} = 19'h0;
  // Pin B shows the device drive when enabled, else the host level.
  assign irq_pin = host_irq_b_oe ? host_irq_b_out : irq_drv;
  always @(posedge mclk) begin
    if (go && host_cs_n) begin
      host_cs_n <= 1'h0;
      {host_rw_n, host_dma_cyc, host_addr} <= cmd;
    end else if (!host_ack_n) begin
      host_cs_n <= 1'h1;
      // Address is not held once select is gone, so it keeps changing.
      host_addr <= ~host_addr;
    end
  end
endmodule : hpic_host

// File: testbench/hpic_top_tb.sv
// Self-checking bench for the host port side-band logic.
`timescale 1ns/100ps
module hpic_top_tb import hpic_pkg::*;;
  logic mclk = 1'h0, nrst = 1'h0, irq_clear = 1'h0, inbound_clear = 1'h0;
  logic access_done = 1'h0, go = 1'h0, irq_drv = 1'h1, strap = 1'h1;
  logic [18:0] cmd;
  hpic_ctl_t   ctl;
  hpic_fifo_t  fifo;
  wire logic cs_n, rw_n, dma, pin, b_out, b_oe, irq_a_n, inb, cpu_irq, dir;
  wire logic a1413, ram_sel, reg_sel, is_rd, xdir, xen_n, ack_n;
  wire logic [16:0] addr;
  int errors = 0, comparisons = 0, cycles = 0, n, e;

  always #2.5 mclk = ~mclk;

  hpic_top i_dut (.mclk(mclk), .nrst(nrst), .irq_b_dir_strap(strap), .ctl(ctl),
    .irq_clear(irq_clear), .inbound_clear(inbound_clear), .fifo(fifo), .host_cs_n(cs_n),
    .host_rw_n(rw_n), .host_dma_cyc(dma), .host_addr(addr), .access_done(access_done),
    .host_irq_b_in(pin), .host_irq_b_out(b_out), .host_irq_b_oe(b_oe),
    .host_irq_a_n(irq_a_n), .inbound_irq_flag(inb), .cpu_irq(cpu_irq), .irq_b_dir_ctl(dir),
    .addr_14_13_ram(a1413), .ram_sel(ram_sel), .reg_sel(reg_sel), .host_is_read(is_rd),
    .xcvr_dir(xdir), .xcvr_en_n(xen_n), .host_ack_n(ack_n));

  hpic_host i_host (.mclk(mclk), .go(go), .cmd(cmd), .irq_drv(irq_drv), .host_ack_n(ack_n),
    .host_irq_b_out(b_out), .host_irq_b_oe(b_oe), .host_cs_n(cs_n), .host_rw_n(rw_n),
    .host_dma_cyc(dma), .host_addr(addr), .irq_pin(pin));

  task check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task finish_test;
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // The whole run needs a few hundred cycles; this ceiling only cuts a hang.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    ctl = '0;
    fifo = '0;
    cmd = '0;
    void'($urandom(45));
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    repeat (3) @(negedge mclk);
    check({dir, irq_a_n, pin, ack_n, xen_n}, 5'h1F);
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      ctl.host_irq_global_en <= i[0];
      ctl.irq_pin_steer <= i[1];
      ctl.status_irq_bit <= (i >> 2) == 0;
      ctl.data_avail_irq_bit <= (i >> 2) == 1;
      fifo.fifo_flag <= i >= 8;
      fifo.fifo_flag_en <= (i >> 2) == 2;
      @(posedge mclk);
      ctl.status_irq_bit <= 1'h0;
      ctl.data_avail_irq_bit <= 1'h0;
      repeat (3) @(negedge mclk);
      check(irq_a_n, !(i < 12 && i[0] && !i[1]));
      check(pin, !(i < 12 && i[0] && i[1]));
      @(posedge mclk);
      fifo.fifo_flag <= 1'h0;
      irq_clear <= 1'h1;
      @(posedge mclk);
      irq_clear <= 1'h0;
      repeat (3) @(negedge mclk);
      check({irq_a_n, pin}, 2'h3);
    end
    @(posedge mclk);
    ctl.irq_b_dir_ctl_wr <= 1'h1;
    @(posedge mclk);
    ctl.irq_b_dir_ctl_wr <= 1'h0;
    irq_drv <= 1'h0;
    repeat (3) @(negedge mclk);
    check({dir, b_oe}, 2'h0);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      @(posedge mclk);
      irq_drv <= 1'h1;
      repeat (12) @(negedge mclk) n += cpu_irq;
      check(n, 1);
      check(inb, 1'h1);
      @(posedge mclk);
      irq_drv <= 1'h0;
      inbound_clear <= 1'h1;
      @(posedge mclk);
      inbound_clear <= 1'h0;
      repeat (8) @(negedge mclk);
      check(inb, 1'h0);
    end
    @(posedge mclk);
    ctl.fifo_mode <= 1'h1;
    ctl.merged_dma_req_en <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      e = $urandom;
      @(posedge mclk);
      fifo.dma_rdy_in <= e[0];
      fifo.dma_rdy_out <= e[1];
      repeat (3) @(negedge mclk);
      check({b_oe, pin, a1413}, {1'h1, e[0] | e[1], 1'h1});
    end
    @(posedge mclk);
    ctl.fifo_dma_en_n <= 1'h1;
    repeat (3) @(negedge mclk);
    check(b_oe, 1'h0);
    for (int k = 0; k < 6; k++) begin
      e = $urandom;
      @(posedge mclk);
      cmd <= e[18:0];
      go <= 1'h1;
      @(posedge mclk);
      go <= 1'h0;
      for (n = 0; n < 50 && xen_n !== 1'h0; n++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      check({xen_n, ram_sel, reg_sel}, {1'h0, !e[16], e[16]});
      check({is_rd, xdir}, {2{e[18] ^ e[17]}});
      @(posedge mclk);
      access_done <= 1'h1;
      @(posedge mclk);
      access_done <= 1'h0;
      for (n = 0; n < 50 && ack_n !== 1'h0; n++) @(negedge mclk);
      check({ack_n, xen_n}, 2'h1);
      for (n = 0; n < 50 && ack_n !== 1'h1; n++) @(negedge mclk);
      check({cs_n, ack_n}, 2'h3);
    end
    // Second reset with the strap low: pin B must come up as an input.
    @(posedge mclk);
    strap <= 1'h0;
    nrst <= 1'h0;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    repeat (3) @(negedge mclk);
    check({dir, b_oe, irq_a_n, ack_n, xen_n}, 5'h07);
    finish_test();
  end
endmodule : hpic_top_tb
